// *** src/nbm_ext.sv ***
`timescale 1ns/1ps
// Contract
// RQ1: nine-bit enable clear gives a plain UART; set sends address/data flag as ninth bit.
// RQ2: auto receive off passes all bytes unchecked; on, address bytes are compared.
// RQ3: compare-only clear lets a compare update the receive gate; set leaves it alone.
// RQ4: direction is held one bit time after a frame, or two with hold-select set.
// RQ5: polarity clear drives direction high receiving, low sending; set inverts both.
// RQ6: auto transmit set clears the address-byte flag after an address byte is sent.
// RQ7: address-store clear drops received address bytes; set writes them into the FIFO.
// RQ8: driver-type set selects half duplex, driving direction to transmit while sending.
// RQ9: eight-bit writable slave address, reset to all ones.
// RQ10: eight-bit writable slave mask, reset to all ones.
// RQ11: eight-bit writable broadcast address, reset to 02h.
// RQ12: interrupt type clear fires on any address byte, set only on a match.
// RQ13: the interrupt output stays low while its enable bit is clear.
// RQ14: a status flag is set once the interrupt has fired and clear otherwise.
// RQ15: deep FIFO enable grows both FIFOs to 128 bytes, else base depth.
// RQ16: receive threshold chosen from level mode and FIFO trigger bits per table.
// RQ17: software writes zeros into reserved bits above the deep FIFO enable.
// RQ18: all registers return to defaults while the bus reset is asserted.
// RQ19: match means broadcast equality, or slave equality in bits the mask keeps.
// RQ20: a match opens the receive gate; a miss closes it until the next address.
module nbm_ext
  import nbm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [10:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic serial_rx_i,
  output logic serial_tx_o,
  output logic request_to_send_o,
  output logic nine_bit_irq_o,
  output logic rx_level_reached_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // a mask bit of one keeps that bit position in the slave comparison
  function automatic logic addr_match(input logic [7:0] a, input logic [7:0] slave,
                                      input logic [7:0] mask, input logic [7:0] bcast);
    addr_match = (a == bcast) || (((a ^ slave) & mask) == 8'h00);
  endfunction : addr_match

  logic [7:0] cfg_q, cfg_d, slave_q, slave_d, mask_q, mask_d, bcast_q, bcast_d;
  logic [7:0] ext_q, ext_d;
  logic [1:0] ictl_q, ictl_d, line_q, line_d, fctl_q, fctl_d;
  logic stat_q, stat_d, ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [8:0] idx;
  logic aligned, wr_hit, tx_push, rx_pop;
  nbm_tx_t tx_state_q, tx_state_d;
  logic [15:0] tx_cnt_q, tx_cnt_d, hold_len_q, hold_len_d;
  logic [7:0] tx_shift_q, tx_shift_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic tx_ninth_q, tx_ninth_d, tx_hold_q, tx_hold_d, tx_line_q, tx_line_d;
  logic tx_bit_end, tx_pop, tx_addr_sent, rts_q, rts_d, dir_tx;
  nbm_rx_t rx_state_q, rx_state_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [7:0] rx_shift_q, rx_shift_d;
  logic [2:0] rx_idx_q, rx_idx_d;
  logic rx_ninth_q, rx_ninth_d, rx_meta_q, rx_sync_q, rx_deliver;
  logic rx_is_addr, rx_matched, rx_push;
  logic [7:0] tx_mem [0:127];
  logic [7:0] rx_mem [0:127];
  logic [7:0] tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d, rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d;
  logic [7:0] tx_count, rx_count, depth_cur, rx_level;
  logic tx_empty, tx_full, rx_empty, rx_full, lvl_q, lvl_d;

  // bus decode; misaligned or unknown addresses read zero and drop writes
  assign idx = avs_address_i[10:2];
  assign aligned = avs_address_i[1:0] == 2'b00;
  assign wr_hit = avs_write_i & ack_q & aligned & avs_byteenable_i[0];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o = rdata_q;
  assign nine_bit_irq_o = stat_q & ictl_q[ICTL_EN]; // RQ13

  // register file: every access takes one wait cycle, read data prepared in it
  always_comb
  begin
    cfg_d = cfg_q;
    slave_d = slave_q;
    mask_d = mask_q;
    bcast_d = bcast_q;
    ictl_d = ictl_q;
    stat_d = stat_q;
    ext_d = ext_q;
    line_d = line_q;
    fctl_d = fctl_q;
    rdata_d = rdata_q;
    ack_d = (avs_read_i | avs_write_i) & ~ack_q;
    tx_push = wr_hit & (idx == IDX_TX_DATA) & ~tx_full;
    rx_pop = avs_read_i & ack_q & aligned & (idx == IDX_RX_DATA) & ~rx_empty;
    if (avs_read_i & ~ack_q)
    begin
      rdata_d = 32'h0000_0000;
      if (aligned)
      begin
        case (idx)
          IDX_MODE_CFG: rdata_d[7:0] = cfg_q;
          IDX_SLAVE_ADDR: rdata_d[7:0] = slave_q;
          IDX_SLAVE_MASK: rdata_d[7:0] = mask_q;
          IDX_BCAST_ADDR: rdata_d[7:0] = bcast_q;
          IDX_IRQ_CTRL: rdata_d[1:0] = ictl_q;
          IDX_IRQ_STATUS: rdata_d[0] = stat_q;
          IDX_EXT_CTRL: rdata_d[7:0] = ext_q;
          IDX_LINE_CTRL: rdata_d[1:0] = line_q;
          // an empty read shows 100h, bit 8 set with zero data, never unwritten storage behind the pointer
          IDX_RX_DATA: rdata_d[8:0] = rx_empty ? 9'h100 : {1'b0, rx_mem[rx_rd_q[6:0]]};
          IDX_FIFO_CTRL: rdata_d[7:6] = fctl_q;
          IDX_FIFO_STATUS: rdata_d[15:0] = {rx_count, tx_count};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
    // hardware clear first so that a software set in the same cycle wins
    if (tx_addr_sent & cfg_q[CFG_AUTO_TX])
      line_d[LINE_ADDR_FLAG] = 1'b0; // RQ6
    if (wr_hit)
    begin
      case (idx)
        IDX_MODE_CFG: cfg_d = avs_writedata_i[7:0];
        IDX_SLAVE_ADDR: slave_d = avs_writedata_i[7:0]; // RQ9
        IDX_SLAVE_MASK: mask_d = avs_writedata_i[7:0]; // RQ10
        IDX_BCAST_ADDR: bcast_d = avs_writedata_i[7:0]; // RQ11
        IDX_IRQ_CTRL: ictl_d = avs_writedata_i[1:0];
        IDX_IRQ_STATUS: stat_d = avs_writedata_i[0];
        IDX_EXT_CTRL: ext_d = avs_writedata_i[7:0] & EXT_WMASK; // RQ17
        IDX_LINE_CTRL: line_d = avs_writedata_i[1:0];
        IDX_FIFO_CTRL: fctl_d = avs_writedata_i[7:6];
        default: ;
      endcase
    end
    // with auto receive on, the address compare result steers the receive gate unless compare-only
    if (rx_deliver & rx_is_addr & cfg_q[CFG_AUTO_RX] & ~cfg_q[CFG_CMP_ONLY])
      line_d[LINE_RX_GATE] = rx_matched; // RQ3 RQ20
    // the event sets the flag even against a clearing write
    if (rx_deliver & rx_is_addr & ictl_q[ICTL_EN] & (~ictl_q[ICTL_TYPE] | rx_matched))
      stat_d = 1'b1; // RQ12 RQ14
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q <= RST_MODE_CFG; // RQ18
      slave_q <= RST_SLAVE_ADDR;
      mask_q <= RST_SLAVE_MASK;
      bcast_q <= RST_BCAST_ADDR;
      ictl_q <= RST_IRQ_CTRL;
      stat_q <= RST_IRQ_STATUS;
      ext_q <= RST_EXT_CTRL;
      line_q <= RST_LINE_CTRL;
      fctl_q <= RST_FIFO_CTRL;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      slave_q <= slave_d;
      mask_q <= mask_d;
      bcast_q <= bcast_d;
      ictl_q <= ictl_d;
      stat_q <= stat_d;
      ext_q <= ext_d;
      line_q <= line_d;
      fctl_q <= fctl_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // fifo bookkeeping; pointers wrap at 256 so any depth up to 128 indexes cleanly
  assign depth_cur = ext_q[EXT_DEEP] ? DEPTH_DEEP : DEPTH_BASE; // RQ15
  assign tx_count = tx_wr_q - tx_rd_q;
  assign rx_count = rx_wr_q - rx_rd_q;
  assign tx_empty = tx_count == 8'h00;
  assign rx_empty = rx_count == 8'h00;
  assign tx_full = tx_count >= depth_cur;
  assign rx_full = rx_count >= depth_cur;
  assign rx_level = RX_LEVEL_TABLE[{ext_q[7:EXT_LVL_LO], fctl_q}]; // RQ16

  always_comb
  begin
    tx_wr_d = tx_wr_q + {7'h00, tx_push};
    tx_rd_d = tx_rd_q + {7'h00, tx_pop};
    rx_wr_d = rx_wr_q + {7'h00, rx_push};
    rx_rd_d = rx_rd_q + {7'h00, rx_pop};
    lvl_d = rx_count >= rx_level; // RQ16
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_wr_q <= 8'h00;
      tx_rd_q <= 8'h00;
      rx_wr_q <= 8'h00;
      rx_rd_q <= 8'h00;
      lvl_q <= 1'b0;
    end
    else
    begin
      tx_wr_q <= tx_wr_d;
      tx_rd_q <= tx_rd_d;
      rx_wr_q <= rx_wr_d;
      rx_rd_q <= rx_rd_d;
      lvl_q <= lvl_d;
    end
  end
  assign rx_level_reached_o = lvl_q;

  // storage arrays carry no reset; contents are only read behind the pointers
  always_ff @(posedge clk_i)
  begin
    if (tx_push)
      tx_mem[tx_wr_q[6:0]] <= avs_writedata_i[7:0];
    if (rx_push)
      rx_mem[rx_wr_q[6:0]] <= rx_shift_q;
  end

  // transmitter: start, eight data, optional flag bit, stop, then direction hold
  assign tx_bit_end = tx_cnt_q == BIT_CYCLES - 16'h0001;
  assign dir_tx = cfg_q[CFG_DRV_SEL] & (tx_state_q != TX_IDLE); // RQ8

  always_comb
  begin
    tx_state_d = tx_state_q;
    tx_shift_d = tx_shift_q;
    tx_idx_d = tx_idx_q;
    tx_ninth_d = tx_ninth_q;
    tx_hold_d = tx_hold_q;
    tx_line_d = tx_line_q;
    tx_cnt_d = tx_bit_end ? 16'h0000 : tx_cnt_q + 16'h0001;
    hold_len_d = (tx_state_q == TX_HOLD) ? hold_len_q + 16'h0001 : 16'h0000;
    tx_pop = 1'b0;
    tx_addr_sent = 1'b0;
    unique case (tx_state_q)
      TX_IDLE:
      begin
        tx_cnt_d = 16'h0000;
        tx_line_d = 1'b1;
        if (!tx_empty)
        begin
          tx_pop = 1'b1;
          tx_shift_d = tx_mem[tx_rd_q[6:0]];
          tx_ninth_d = cfg_q[CFG_NINE_EN] & line_q[LINE_ADDR_FLAG]; // RQ1
          tx_line_d = 1'b0;
          tx_state_d = TX_START;
        end
      end
      TX_START:
        if (tx_bit_end)
        begin
          tx_idx_d = 3'h0;
          tx_line_d = tx_shift_q[0];
          tx_state_d = TX_DATA;
        end
      TX_DATA:
        if (tx_bit_end)
        begin
          tx_shift_d = {1'b0, tx_shift_q[7:1]};
          tx_idx_d = tx_idx_q + 3'h1;
          tx_line_d = tx_shift_q[1];
          if (tx_idx_q == 3'h7)
          begin
            // plain mode sends no flag bit at all
            tx_line_d = cfg_q[CFG_NINE_EN] ? tx_ninth_q : 1'b1; // RQ1
            tx_state_d = cfg_q[CFG_NINE_EN] ? TX_NINTH : TX_STOP;
          end
        end
      TX_NINTH:
        if (tx_bit_end)
        begin
          tx_line_d = 1'b1;
          tx_state_d = TX_STOP;
        end
      TX_STOP:
        if (tx_bit_end)
        begin
          tx_addr_sent = tx_ninth_q; // RQ6
          tx_hold_d = 1'b0;
          tx_state_d = TX_HOLD;
        end
      TX_HOLD:
        // keeps the transceiver turned round while the last stop bit settles
        if (tx_bit_end)
        begin
          tx_hold_d = 1'b1;
          if (tx_hold_q == cfg_q[CFG_HOLD_SEL] || tx_hold_q)
            tx_state_d = TX_IDLE; // RQ4
        end
      default: tx_state_d = TX_IDLE;
    endcase
    rts_d = cfg_q[CFG_DIR_POL] ? dir_tx : ~dir_tx; // RQ5
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= 16'h0000;
      hold_len_q <= 16'h0000;
      tx_shift_q <= 8'h00;
      tx_idx_q <= 3'h0;
      tx_ninth_q <= 1'b0;
      tx_hold_q <= 1'b0;
      tx_line_q <= 1'b1;
      rts_q <= 1'b1;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_cnt_q <= tx_cnt_d;
      hold_len_q <= hold_len_d;
      tx_shift_q <= tx_shift_d;
      tx_idx_q <= tx_idx_d;
      tx_ninth_q <= tx_ninth_d;
      tx_hold_q <= tx_hold_d;
      tx_line_q <= tx_line_d;
      rts_q <= rts_d;
    end
  end
  assign serial_tx_o = tx_line_q;
  assign request_to_send_o = rts_q;

  // receiver samples mid-bit; a bad stop bit drops the character silently
  assign rx_is_addr = cfg_q[CFG_NINE_EN] & rx_ninth_q;
  assign rx_matched = addr_match(rx_shift_q, slave_q, mask_q, bcast_q); // RQ19

  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_shift_d = rx_shift_q;
    rx_idx_d = rx_idx_q;
    rx_ninth_d = rx_ninth_q;
    rx_cnt_d = rx_cnt_q + 16'h0001;
    rx_deliver = 1'b0;
    unique case (rx_state_q)
      RX_IDLE:
      begin
        rx_cnt_d = 16'h0000;
        if (!rx_sync_q)
        begin
          rx_ninth_d = 1'b0;
          rx_state_d = RX_START;
        end
      end
      RX_START:
        if (rx_cnt_q == HALF_CYCLES - 16'h0001)
        begin
          rx_cnt_d = 16'h0000;
          rx_idx_d = 3'h0;
          rx_state_d = rx_sync_q ? RX_IDLE : RX_DATA;
        end
      RX_DATA:
        if (rx_cnt_q == BIT_CYCLES - 16'h0001)
        begin
          rx_cnt_d = 16'h0000;
          rx_shift_d = {rx_sync_q, rx_shift_q[7:1]};
          rx_idx_d = rx_idx_q + 3'h1;
          if (rx_idx_q == 3'h7)
            rx_state_d = cfg_q[CFG_NINE_EN] ? RX_NINTH : RX_STOP; // RQ1
        end
      RX_NINTH:
        if (rx_cnt_q == BIT_CYCLES - 16'h0001)
        begin
          rx_cnt_d = 16'h0000;
          rx_ninth_d = rx_sync_q;
          rx_state_d = RX_STOP;
        end
      RX_STOP:
        if (rx_cnt_q == BIT_CYCLES - 16'h0001)
        begin
          rx_deliver = rx_sync_q;
          rx_state_d = RX_IDLE;
        end
      default: rx_state_d = RX_IDLE;
    endcase
    // address bytes stored only on request; with auto receive, data is dropped while the gate is closed
    if (rx_is_addr)
      rx_push = rx_deliver & cfg_q[CFG_ADDR_STORE] & ~rx_full; // RQ7
    else
      rx_push = rx_deliver & ~rx_full & (~cfg_q[CFG_NINE_EN] | ~cfg_q[CFG_AUTO_RX] |
                                         line_q[LINE_RX_GATE]); // RQ2 RQ20
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_shift_q <= 8'h00;
      rx_idx_q <= 3'h0;
      rx_ninth_q <= 1'b0;
    end
    else
    begin
      rx_meta_q <= serial_rx_i;
      rx_sync_q <= rx_meta_q;
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rx_shift_q <= rx_shift_d;
      rx_idx_q <= rx_idx_d;
      rx_ninth_q <= rx_ninth_d;
    end
  end

  // checks
  localparam logic [15:0] HOLD_ONE = BIT_CYCLES - 16'h0001;
  localparam logic [15:0] HOLD_TWO = BIT_CYCLES + BIT_CYCLES - 16'h0001;
  sequence s_addr_rx;
    rx_deliver && rx_is_addr;
  endsequence
  sequence s_bus_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence

  property p_irq_masked;
    !ictl_q[ICTL_EN] |-> !nine_bit_irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq high while disabled"); // RQ13

  property p_any_addr_irq;
    s_addr_rx ##0 (ictl_q == 2'b01) |=> stat_q ##0 nine_bit_irq_o;
  endproperty
  a_any_addr_irq: assert property (p_any_addr_irq) else $error("addr irq missing"); // RQ12

  property p_gate_follow;
    s_addr_rx ##0 (cfg_q[CFG_AUTO_RX] && !cfg_q[CFG_CMP_ONLY]) |=>
      line_q[LINE_RX_GATE] == $past(rx_matched);
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("gate not updated"); // RQ3

  property p_cmp_only;
    s_addr_rx ##0 (cfg_q[CFG_CMP_ONLY] && !(wr_hit && idx == IDX_LINE_CTRL)) |=>
      $stable(line_q[LINE_RX_GATE]);
  endproperty
  a_cmp_only: assert property (p_cmp_only) else $error("gate changed in compare-only"); // RQ3

  property p_addr_store;
    s_addr_rx ##0 !cfg_q[CFG_ADDR_STORE] |=> $stable(rx_wr_q);
  endproperty
  a_addr_store: assert property (p_addr_store) else $error("address byte stored"); // RQ7

  property p_flag_clear;
    tx_addr_sent && cfg_q[CFG_AUTO_TX] && !(wr_hit && idx == IDX_LINE_CTRL) |=>
      !line_q[LINE_ADDR_FLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("address flag kept"); // RQ6

  property p_dir_sending;
    (tx_state_q == TX_DATA) && cfg_q[CFG_DRV_SEL] && !cfg_q[CFG_DIR_POL] |=> !request_to_send_o;
  endproperty
  a_dir_sending: assert property (p_dir_sending) else $error("direction not low"); // RQ5

  property p_hold_len;
    (tx_state_q == TX_HOLD) && (tx_state_d == TX_IDLE) |->
      hold_len_q == (cfg_q[CFG_HOLD_SEL] ? HOLD_TWO : HOLD_ONE);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("direction hold wrong"); // RQ4

  property p_plain_frame;
    (tx_state_q == TX_DATA) && tx_bit_end && (tx_idx_q == 3'h7) && !cfg_q[CFG_NINE_EN] |=>
      (tx_state_q == TX_STOP) && serial_tx_o;
  endproperty
  a_plain_frame: assert property (p_plain_frame) else $error("flag bit in plain mode"); // RQ1

  property p_depth;
    (tx_count <= depth_cur) && (rx_count <= depth_cur);
  endproperty
  a_depth: assert property (p_depth) else $error("fifo over depth"); // RQ15

  property p_bus_wait;
    (avs_read_i || avs_write_i) && !ack_q |-> s_bus_wait;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("waitrequest timing");

endmodule : nbm_ext

// *** src/nbm_pkg.sv ***
package nbm_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [8:0] IDX_MODE_CFG = 9'h0F2;
  localparam logic [8:0] IDX_SLAVE_ADDR = 9'h0F3;
  localparam logic [8:0] IDX_SLAVE_MASK = 9'h0F4;
  localparam logic [8:0] IDX_BCAST_ADDR = 9'h0F5;
  localparam logic [8:0] IDX_IRQ_CTRL = 9'h0F6;
  localparam logic [8:0] IDX_IRQ_STATUS = 9'h0F7;
  localparam logic [8:0] IDX_EXT_CTRL = 9'h0F8;
  localparam logic [8:0] IDX_LINE_CTRL = 9'h0F9;
  localparam logic [8:0] IDX_TX_DATA = 9'h0FA;
  localparam logic [8:0] IDX_RX_DATA = 9'h0FB;
  localparam logic [8:0] IDX_FIFO_CTRL = 9'h0FC;
  localparam logic [8:0] IDX_FIFO_STATUS = 9'h0FD;

  // mode configuration bit positions
  localparam int CFG_AUTO_RX = 7;
  localparam int CFG_CMP_ONLY = 6;
  localparam int CFG_HOLD_SEL = 5;
  localparam int CFG_DIR_POL = 4;
  localparam int CFG_AUTO_TX = 3;
  localparam int CFG_ADDR_STORE = 2;
  localparam int CFG_DRV_SEL = 1;
  localparam int CFG_NINE_EN = 0;
  // interrupt control, status, extended control, line control, fifo control
  localparam int ICTL_TYPE = 1;
  localparam int ICTL_EN = 0;
  localparam int EXT_DEEP = 0;
  localparam int EXT_LVL_LO = 6;
  localparam logic [7:0] EXT_WMASK = 8'hC1;
  localparam int LINE_ADDR_FLAG = 0;
  localparam int LINE_RX_GATE = 1;
  localparam int FCTL_TRIG_LO = 6;

  // values after reset
  localparam logic [7:0] RST_MODE_CFG = 8'h00;
  localparam logic [7:0] RST_SLAVE_ADDR = 8'hFF;
  localparam logic [7:0] RST_SLAVE_MASK = 8'hFF;
  localparam logic [7:0] RST_BCAST_ADDR = 8'h02;
  localparam logic [1:0] RST_IRQ_CTRL = 2'h0;
  localparam logic RST_IRQ_STATUS = 1'b0;
  localparam logic [7:0] RST_EXT_CTRL = 8'h00;
  localparam logic [1:0] RST_LINE_CTRL = 2'h0;
  localparam logic [1:0] RST_FIFO_CTRL = 2'h0;

  // line timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_CYCLES = 16'(CLK_HZ / BAUD_HZ / 2);

  // fifo depths and receive trigger levels, indexed {level mode, trigger bits}
  localparam logic [7:0] DEPTH_BASE = 8'h10;
  localparam logic [7:0] DEPTH_DEEP = 8'h80;
  localparam logic [7:0] RX_LEVEL_TABLE [0:15] = '{
    8'h01, 8'h04, 8'h08, 8'h0E, 8'h10, 8'h20, 8'h30, 8'h40,
    8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7C};

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_HOLD} nbm_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} nbm_rx_t;
endpackage : nbm_pkg

// *** tb/nbm_line_model.sv ***
`timescale 1ns/1ps
// transceiver on the far side: decodes nine-bit frames, sends frames
module nbm_line_model
  import nbm_pkg::*;
(
  input wire logic clk_i,
  input wire logic line_in_i,
  output logic line_out_o
);
  logic [8:0] rx_word;
  int rx_count;

  // idle line is high, like a biased bus with nobody driving
  initial
  begin
    line_out_o = 1'b1;
    rx_count = 0;
  end

  // sample at bit centres, lsb first, flag bit last before stop
  always
  begin
    @(negedge line_in_i);
    repeat (434) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      repeat (868) @(posedge clk_i);
      if (i < 9)
        rx_word[i] = line_in_i;
    end
    rx_count++;
  end

  // one start bit, eight data bits, flag bit, one stop bit
  task automatic send(input logic [8:0] w);
    line_out_o <= 1'b0;
    repeat (868) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      line_out_o <= w[i];
      repeat (868) @(posedge clk_i);
    end
    line_out_o <= 1'b1;
    repeat (868) @(posedge clk_i);
  endtask : send
endmodule : nbm_line_model

// *** tb/tb_uart_nine_bit_multidrop_ext.sv ***
`timescale 1ns/1ps
module tb_uart_nine_bit_multidrop_ext
  import nbm_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [10:0] avs_address_i = 11'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic serial_rx_i;
  logic serial_tx_o;
  logic request_to_send_o;
  logic nine_bit_irq_o;
  logic rx_level_reached_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk_i = ~clk_i;

  nbm_ext dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .serial_rx_i(serial_rx_i),
    .serial_tx_o(serial_tx_o), .request_to_send_o(request_to_send_o),
    .nine_bit_irq_o(nine_bit_irq_o), .rx_level_reached_o(rx_level_reached_o));

  nbm_line_model xcvr (.clk_i(clk_i), .line_in_i(serial_tx_o), .line_out_o(serial_rx_i));

  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // a hung handshake or frame ends the run as a failure; eight frames need about 80k cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bus write: request held until waitrequest is seen low
  task automatic bw(input logic [8:0] ix, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i <= {ix, 2'b00};
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask : bw

  // bus read: data taken at the edge that sees waitrequest low
  task automatic rdchk(input logic [8:0] ix, input logic [31:0] exp);
    @(posedge clk_i);
    avs_address_i <= {ix, 2'b00};
    avs_read_i <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    chk(avs_readdata_o, exp);
    avs_read_i <= 1'b0;
  endtask : rdchk

  task automatic t_regs();
    logic [8:0] ix [7] = '{IDX_MODE_CFG, IDX_SLAVE_ADDR, IDX_SLAVE_MASK, IDX_BCAST_ADDR,
      IDX_IRQ_CTRL, IDX_IRQ_STATUS, IDX_EXT_CTRL};
    logic [7:0] rv [7] = '{8'h00, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++)
      rdchk(ix[i], {24'h000000, rv[i]});
    rdchk(9'h000, 32'h00000000);
    chk(request_to_send_o, 32'h1);
    bw(IDX_SLAVE_ADDR, 8'h5A);
    rdchk(IDX_SLAVE_ADDR, 32'h5A);
    bw(IDX_SLAVE_MASK, 8'hF0);
    rdchk(IDX_SLAVE_MASK, 32'hF0);
    bw(IDX_BCAST_ADDR, 8'h3C);
    rdchk(IDX_BCAST_ADDR, 32'h3C);
    bw(IDX_EXT_CTRL, 8'hC1);
    rdchk(IDX_EXT_CTRL, 32'hC1);
    bw(IDX_EXT_CTRL, 8'h00);
  endtask : t_regs

  // one frame out in half duplex with the address flag set; direction returns after the hold
  task automatic tx_frame(input logic [7:0] cfg, input logic [7:0] d, input logic [31:0] exp);
    int seen;
    seen = xcvr.rx_count;
    bw(IDX_MODE_CFG, cfg);
    bw(IDX_LINE_CTRL, 8'h01);
    bw(IDX_TX_DATA, d);
    repeat (3) @(posedge clk_i);
    chk(request_to_send_o, 32'h0);
    while (xcvr.rx_count == seen) @(posedge clk_i);
    chk(xcvr.rx_word, exp);
    repeat (1250) @(posedge clk_i);
    chk(request_to_send_o, 32'h0);
    repeat (150) @(posedge clk_i);
    chk(request_to_send_o, 32'h1);
  endtask : tx_frame

  // nine-bit address frame with one-bit hold, then a plain frame with two-bit hold;
  // the plain frame is one bit shorter, so both fall back inside the same window
  task automatic t_tx();
    tx_frame(8'h0B, 8'hA5, 32'h1A5);
    rdchk(IDX_LINE_CTRL, 32'h0);
    tx_frame(8'h2A, 8'hC3, 32'h1C3);
    rdchk(IDX_LINE_CTRL, 32'h1);
    bw(IDX_MODE_CFG, 8'h1B);
    repeat (3) @(posedge clk_i);
    chk(request_to_send_o, 32'h0);
    bw(IDX_LINE_CTRL, 8'h00);
  endtask : t_tx

  // one received address frame, then the expected flags
  task automatic rx_addr(input logic [7:0] a, input logic [31:0] hit);
    bw(IDX_IRQ_STATUS, 8'h00);
    xcvr.send({1'b1, a});
    repeat (10) @(posedge clk_i);
    chk(nine_bit_irq_o, hit);
    rdchk(IDX_IRQ_STATUS, hit);
    rdchk(IDX_LINE_CTRL, {hit[30:0], 1'b0});
  endtask : rx_addr

  task automatic t_rx();
    bw(IDX_IRQ_CTRL, 8'h03);
    bw(IDX_MODE_CFG, 8'h85);
    rx_addr(8'h5F, 32'h1);
    chk(rx_level_reached_o, 32'h1);
    rdchk(IDX_RX_DATA, 32'h5F);
    rdchk(IDX_RX_DATA, 32'h100);
    bw(IDX_IRQ_CTRL, 8'h02);
    @(posedge clk_i);
    chk(nine_bit_irq_o, 32'h0);
    chk(rx_level_reached_o, 32'h0);
    bw(IDX_IRQ_CTRL, 8'h03);
    rx_addr(8'h33, 32'h0);
    xcvr.send({1'b0, 8'h77});
    rx_addr(8'h3C, 32'h1);
    xcvr.send({1'b0, 8'h66});
  endtask : t_rx

  // compare-only keeps the gate open after a miss; dropped address; drain the fifo
  task automatic t_gate();
    bw(IDX_MODE_CFG, 8'hC1);
    bw(IDX_IRQ_CTRL, 8'h01);
    rx_addr(8'h33, 32'h1);
    rdchk(IDX_FIFO_STATUS, 32'h0300);
    rdchk(IDX_RX_DATA, 32'h33);
    rdchk(IDX_RX_DATA, 32'h3C);
    rdchk(IDX_RX_DATA, 32'h66);
    rdchk(IDX_RX_DATA, 32'h100);
  endtask : t_gate

  // a bus reset in mid-run puts every register and pointer back to its default
  task automatic t_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk(IDX_SLAVE_ADDR, 32'hFF);
    rdchk(IDX_BCAST_ADDR, 32'h02);
    rdchk(IDX_MODE_CFG, 32'h00);
    rdchk(IDX_FIFO_STATUS, 32'h0000);
    chk(nine_bit_irq_o, 32'h0);
  endtask : t_reset

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_gate();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_uart_nine_bit_multidrop_ext
